// *** verilog/panel_clock_timing.sv ***
`timescale 1ns/1ns
module panel_clock_timing
   import panel_timing_pkg::*;
(
   // system
   input  wire logic                    sys_clk,
   input  wire logic                    resetn,
   // wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // clock pins and select
   input  wire logic                    clock_source_select,
   input  wire logic                    memory_clock_pin_i,
   output logic                         memory_clock_pin_o,
   output logic                         memory_clock_pin_oe,
   input  wire logic                    video_clock_pin_i,
   output logic                         video_clock_pin_o,
   output logic                         video_clock_pin_oe,
   output logic                         synth_enable,
   // link domain: pixel clock chosen outside by the select pin
   input  wire logic                    link_clk,
   // panel pins
   output logic                         frame_start_marker,
   output logic                         line_pulse,
   output logic                         panel_shift_clock,
   output logic                         second_shift_clock,
   output logic                         panel_h_display_enable,
   output logic                         panel_logic_power_ctl,
   output logic                         panel_bias_power_ctl
);
   import panel_timing_pkg::*;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   always_ff @(posedge sys_clk)
   begin
      pin_s1_r <= {clock_source_select, video_clock_pin_i, memory_clock_pin_i};
      pin_s2_r <= pin_s1_r;
   end
   logic ext_mode;
   assign ext_mode = pin_s2_r[2];

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0]  pin_function_r;
   logic [1:0]  output_control_r;
   logic [4:0]  panel_control_r;
   logic [11:0] h_total_r;
   logic [11:0] h_active_r;
   logic [11:0] v_total_r;
   logic [11:0] v_active_r;
   logic        bus_req;
   logic        bus_wr;
   logic        cfg_flag_r;
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // a write lands at the edge where the master sees ack high, as the bus asks
   assign bus_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

   // every accepted write flips this flag, which tells the link side to reload
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         cfg_flag_r <= 1'b0;
      else if (bus_wr)
         cfg_flag_r <= !cfg_flag_r;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         pin_function_r   <= RST_PIN_FUNCTION;
         output_control_r <= RST_OUTPUT_CTL;
         panel_control_r  <= RST_PANEL_CTL;
         h_total_r        <= RST_H_TOTAL;
         h_active_r       <= RST_H_ACTIVE;
         v_total_r        <= RST_V_TOTAL;
         v_active_r       <= RST_V_ACTIVE;
      end
      else if (bus_wr)
      begin
         unique case (wb_adr_i)
            OFS_PIN_FUNCTION:   pin_function_r   <= wb_dat_i[7:0];
            OFS_OUTPUT_CONTROL: output_control_r <= wb_dat_i[1:0];
            OFS_PANEL_CONTROL:  panel_control_r  <= wb_dat_i[4:0];
            OFS_H_TIMING:
            begin
               h_total_r  <= wb_dat_i[11:0];
               h_active_r <= wb_dat_i[27:16];
            end
            OFS_V_TIMING:
            begin
               v_total_r  <= wb_dat_i[11:0];
               v_active_r <= wb_dat_i[27:16];
            end
            default: ;
         endcase
      end
   end

   logic [31:0] status_word;
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[ST_EXT_MODE] = ext_mode;
      // status bits only reflect pins set to status use
      status_word[ST_BIT_FOUR]  = pin_function_r[FN_MCLK_STATUS] & pin_s2_r[0];
      status_word[ST_BIT_THREE] = pin_function_r[FN_VCLK_STATUS] & pin_s2_r[1];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= READ_UNMAPPED;
      end
      else
      begin
         wb_ack_o <= bus_req;
         if (bus_req)
         begin
            unique case (wb_adr_i)
               OFS_PIN_FUNCTION:   wb_dat_o <= {24'h000000, pin_function_r};
               OFS_GENERAL_STATUS: wb_dat_o <= status_word;
               OFS_OUTPUT_CONTROL: wb_dat_o <= {30'h0, output_control_r};
               OFS_PANEL_CONTROL:  wb_dat_o <= {27'h0, panel_control_r};
               OFS_H_TIMING:       wb_dat_o <= {4'h0, h_active_r, 4'h0, h_total_r};
               OFS_V_TIMING:       wb_dat_o <= {4'h0, v_active_r, 4'h0, v_total_r};
               default:            wb_dat_o <= READ_UNMAPPED;
            endcase
         end
      end
   end

   // ****************************************************************
   // clock pin steering
   // ****************************************************************
   // observed clocks are the link clock divided by two: a clock cannot
   // leave through a flip-flop at its own rate
   logic link_rst_s1_r;
   logic link_rst_s2_r;
   always_ff @(posedge link_clk)
   begin
      link_rst_s1_r <= resetn;
      link_rst_s2_r <= link_rst_s1_r;
   end

   logic obs_div_r;
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_s2_r)
         obs_div_r <= 1'b0;
      else
         obs_div_r <= !obs_div_r;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         synth_enable        <= 1'b0;
         memory_clock_pin_oe <= 1'b0;
         video_clock_pin_oe  <= 1'b0;
      end
      else
      begin
         synth_enable <= !ext_mode;
         // memory pin drives only in internal mode, not as status or spread input; video pin also drives whenever spread is set
         memory_clock_pin_oe <= !ext_mode && !pin_function_r[FN_MCLK_STATUS]
                                && !pin_function_r[FN_SPREAD];
         video_clock_pin_oe  <= pin_function_r[FN_SPREAD] ||
                                (!ext_mode && !pin_function_r[FN_VCLK_STATUS]);
      end
   end

   // ****************************************************************
   // link domain: panel timing
   // ****************************************************************
   // wide timing words would tear through per-bit flops; the link copy reloads
   // only once the write flag has crossed, so the words have stood still a while
   // limitation: writes closer than three link cycles may tear the copy briefly
   timing_cfg_s cfg_src;
   timing_cfg_s cfg_s2_r;
   logic [2:0]  cfg_flag_sync_r;
   logic [1:0]  pwr_s1_r;
   logic [1:0]  pwr_s2_r;
   logic [1:0]  gpo_s1_r;
   logic [1:0]  gpo_s2_r;
   assign cfg_src = '{h_total: h_total_r, h_active: h_active_r, v_total: v_total_r,
                      v_active: v_active_r, enable: panel_control_r[PC_ENABLE],
                      dual: panel_control_r[PC_DUAL], ac_mode: panel_control_r[PC_AC_MODE]};

   // power and output bits are independent levels: two flops each suffice
   always_ff @(posedge link_clk)
   begin
      cfg_flag_sync_r <= {cfg_flag_sync_r[1:0], cfg_flag_r};
      pwr_s1_r        <= {panel_control_r[PC_BIAS_PWR], panel_control_r[PC_LOGIC_PWR]};
      pwr_s2_r        <= pwr_s1_r;
      gpo_s1_r        <= output_control_r;
      gpo_s2_r        <= gpo_s1_r;
   end

   always_ff @(posedge link_clk)
   begin
      if (!link_rst_s2_r)
         cfg_s2_r <= '{h_total: RST_H_TOTAL, h_active: RST_H_ACTIVE, v_total: RST_V_TOTAL,
                       v_active: RST_V_ACTIVE, enable: RST_PANEL_CTL[PC_ENABLE],
                       dual: RST_PANEL_CTL[PC_DUAL], ac_mode: RST_PANEL_CTL[PC_AC_MODE]};
      else if (cfg_flag_sync_r[2] != cfg_flag_sync_r[1])
         cfg_s2_r <= cfg_src;
   end

   logic [11:0] h_cnt_r;
   logic [11:0] v_cnt_r;
   logic        mod_r;
   logic        h_end;
   logic        v_end;
   assign h_end = (h_cnt_r >= cfg_s2_r.h_total - 12'h001);
   assign v_end = (v_cnt_r >= cfg_s2_r.v_total - 12'h001);

   always_ff @(posedge link_clk)
   begin
      if (!link_rst_s2_r || !cfg_s2_r.enable)
      begin
         h_cnt_r <= 12'h000;
         v_cnt_r <= 12'h000;
      end
      else if (h_end)
      begin
         h_cnt_r <= 12'h000;
         v_cnt_r <= v_end ? 12'h000 : v_cnt_r + 12'h001;
      end
      else
         h_cnt_r <= h_cnt_r + 12'h001;
   end

   // modulation toggles every frame to keep the liquid crystal AC
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_s2_r)
         mod_r <= 1'b0;
      else if (cfg_s2_r.enable && h_end && v_end)
         mod_r <= !mod_r;
   end

   panel_pins_s pins_r;
   logic        active;
   logic        half_sel;
   logic [1:0]  pwr_r;
   assign active   = cfg_s2_r.enable && (h_cnt_r < cfg_s2_r.h_active)
                     && (v_cnt_r < cfg_s2_r.v_active);
   assign half_sel = h_cnt_r[0];

   always_ff @(posedge link_clk)
   begin
      if (!link_rst_s2_r)
      begin
         pins_r <= '0;
         pwr_r  <= 2'h0;
      end
      else
      begin
         pins_r.frame_start <= cfg_s2_r.enable && (v_cnt_r == 12'h000)
                               && (h_cnt_r == 12'h000);
         pins_r.line_pulse  <= cfg_s2_r.enable && h_end;
         pins_r.shift1      <= active && !half_sel;
         pins_r.shift2      <= cfg_s2_r.dual ? (active && half_sel)
                               : (gpo_s2_r[OC_GPO_SEL] & gpo_s2_r[OC_GPO_VAL]);
         pins_r.hde_or_mod  <= cfg_s2_r.ac_mode ? mod_r : active;
         pwr_r              <= pwr_s2_r;
      end
   end

   always_ff @(posedge link_clk)
   begin
      memory_clock_pin_o     <= obs_div_r;
      video_clock_pin_o      <= obs_div_r;
      frame_start_marker     <= pins_r.frame_start;
      line_pulse             <= pins_r.line_pulse;
      panel_shift_clock      <= pins_r.shift1;
      second_shift_clock     <= pins_r.shift2;
      panel_h_display_enable <= pins_r.hde_or_mod;
      panel_logic_power_ctl  <= pwr_r[0];
      panel_bias_power_ctl   <= pwr_r[1];
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_synth_follows_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(ext_mode) |=> !synth_enable)
      else $error("synthesizer still enabled in external mode");

   a_line_pulse_end: assert property (@(posedge link_clk) disable iff (!link_rst_s2_r)
      (cfg_s2_r.enable && h_end) |=> pins_r.line_pulse)
      else $error("line pulse missing at line end");

   a_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");

   a_mclk_status_off: assert property (@(posedge sys_clk) disable iff (!resetn)
      (bus_req && wb_adr_i == OFS_GENERAL_STATUS && !pin_function_r[FN_MCLK_STATUS])
      |=> !wb_dat_o[ST_BIT_FOUR])
      else $error("status bit four set while pin not in status use");

   a_spread_ref_out: assert property (@(posedge sys_clk) disable iff (!resetn)
      pin_function_r[FN_SPREAD] |=> video_clock_pin_oe)
      else $error("spread reference not driven");

   a_spread_in_float: assert property (@(posedge sys_clk) disable iff (!resetn)
      pin_function_r[FN_SPREAD] |=> !memory_clock_pin_oe)
      else $error("memory pin driven while spread input selected");

   a_shift_in_active: assert property (@(posedge link_clk) disable iff (!link_rst_s2_r)
      pins_r.shift1 |-> $past(active))
      else $error("shift clock outside active interval");

   a_mod_toggles: assert property (@(posedge link_clk) disable iff (!link_rst_s2_r)
      (cfg_s2_r.enable && h_end && v_end) |=> (mod_r != $past(mod_r)))
      else $error("modulation did not toggle at frame end");

   a_ext_mem_float: assert property (@(posedge sys_clk) disable iff (!resetn)
      ext_mode |=> !memory_clock_pin_oe)
      else $error("memory clock pin driven in external mode");

   a_obs_mem_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!ext_mode && !pin_function_r[FN_MCLK_STATUS] && !pin_function_r[FN_SPREAD])
      |=> memory_clock_pin_oe)
      else $error("internal memory clock not brought out");

   a_obs_vid_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!ext_mode && !pin_function_r[FN_VCLK_STATUS]) |=> video_clock_pin_oe)
      else $error("internal video clock not brought out");

   a_vclk_status_off: assert property (@(posedge sys_clk) disable iff (!resetn)
      (bus_req && wb_adr_i == OFS_GENERAL_STATUS && !pin_function_r[FN_VCLK_STATUS])
      |=> !wb_dat_o[ST_BIT_THREE])
      else $error("status bit three set while pin not in status use");

   a_frame_mark: assert property (@(posedge link_clk) disable iff (!link_rst_s2_r)
      (cfg_s2_r.enable && v_cnt_r == 12'h000 && h_cnt_r == 12'h000)
      |=> pins_r.frame_start)
      else $error("frame start marker missing");

   a_gpo_level: assert property (@(posedge link_clk) disable iff (!link_rst_s2_r)
      (!cfg_s2_r.dual && gpo_s2_r[OC_GPO_SEL])
      |=> (pins_r.shift2 == $past(gpo_s2_r[OC_GPO_VAL])))
      else $error("second shift clock not following general output");

   a_hde_idle: assert property (@(posedge link_clk) disable iff (!link_rst_s2_r)
      (!cfg_s2_r.ac_mode && !active) |=> !pins_r.hde_or_mod)
      else $error("display enable outside active interval");

   a_logic_pwr: assert property (@(posedge link_clk) disable iff (!link_rst_s2_r)
      pwr_r[0] |=> panel_logic_power_ctl)
      else $error("logic power control not following");

   a_bias_pwr: assert property (@(posedge link_clk) disable iff (!link_rst_s2_r)
      pwr_r[1] |=> panel_bias_power_ctl)
      else $error("bias power control not following");

endmodule

// *** common/panel_timing_pkg.sv ***
package panel_timing_pkg;

   // ****************************************************************
   // register map (byte addresses, one word each)
   // ****************************************************************
   localparam logic [7:0] OFS_PIN_FUNCTION   = 8'h00;
   localparam logic [7:0] OFS_GENERAL_STATUS = 8'h04;
   localparam logic [7:0] OFS_OUTPUT_CONTROL = 8'h08;
   localparam logic [7:0] OFS_PANEL_CONTROL  = 8'h0C;
   localparam logic [7:0] OFS_H_TIMING       = 8'h10;
   localparam logic [7:0] OFS_V_TIMING       = 8'h14;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int FN_MCLK_STATUS = 0;
   localparam int FN_VCLK_STATUS = 1;
   localparam int FN_SPREAD      = 7;
   localparam int ST_BIT_FOUR    = 1;
   localparam int ST_BIT_THREE   = 2;
   localparam int ST_EXT_MODE    = 0;
   localparam int OC_GPO_SEL     = 0;
   localparam int OC_GPO_VAL     = 1;
   localparam int PC_ENABLE      = 0;
   localparam int PC_DUAL        = 1;
   localparam int PC_AC_MODE     = 2;
   localparam int PC_LOGIC_PWR   = 3;
   localparam int PC_BIAS_PWR    = 4;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0]  RST_PIN_FUNCTION = 8'h00;
   localparam logic [1:0]  RST_OUTPUT_CTL   = 2'h0;
   localparam logic [4:0]  RST_PANEL_CTL    = 5'h00;
   localparam logic [11:0] RST_H_TOTAL      = 12'h020;
   localparam logic [11:0] RST_H_ACTIVE     = 12'h010;
   localparam logic [11:0] RST_V_TOTAL      = 12'h010;
   localparam logic [11:0] RST_V_ACTIVE     = 12'h008;
   localparam logic [31:0] READ_UNMAPPED    = 32'h0000_0000;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [11:0] h_total;
      logic [11:0] h_active;
      logic [11:0] v_total;
      logic [11:0] v_active;
      logic        enable;
      logic        dual;
      logic        ac_mode;
   } timing_cfg_s;

   typedef struct packed {
      logic frame_start;
      logic line_pulse;
      logic shift1;
      logic shift2;
      logic hde_or_mod;
   } panel_pins_s;

endpackage

// *** dv/clock_far_side.sv ***
`timescale 1ns/1ns
// ****************************************************************
// external clock sources and status levels on the shared clock pins
// ****************************************************************
module clock_far_side
(
   // from the bench
   input  wire logic link_clk,
   input  wire logic ext_mode,
   input  wire logic mem_level,
   input  wire logic vid_level,
   // shared pins
   input  wire logic mem_o,
   input  wire logic mem_oe,
   input  wire logic vid_o,
   input  wire logic vid_oe,
   output logic      mem_i,
   output logic      vid_i
);
   logic ext_clk_r;

   // the source clock runs only in external mode, it stands still otherwise
   always_ff @(posedge link_clk)
   begin
      ext_clk_r <= ext_mode ? !ext_clk_r : 1'b0;
   end

   // wire level: the device wins while it drives, else the outside source
   assign mem_i = mem_oe ? mem_o : (ext_mode ? ext_clk_r : mem_level);
   assign vid_i = vid_oe ? vid_o : (ext_mode ? ext_clk_r : vid_level);
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ns
module testbench;
   import panel_timing_pkg::*;
   logic        sys_clk, link_clk, resetn, cyc, stb, we, ext_sel, mem_lvl, vid_lvl;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, dat_o, q;
   logic        ack, mem_i, mem_o, mem_oe, vid_i, vid_o, vid_oe, synth_en;
   logic        fsm, lp, sc1, sc2, hde, lpwr, bpwr, fs_q, lp_q, sc1_q, sc2_q, hde_fs;
   int          miscompares = 0, n_compared = 0, cycles = 0, frames = 0, lines = 0;
   int          lines_last = 0, hde_cyc = 0, sc1_up = 0, sc2_up = 0, flips = 0, f0;
   int          hde_frame = 0, hde_last = 0, mo_up = 0, vo_up = 0, s0, m0;
   logic        mo_q, vo_q;

   panel_clock_timing panel_clock_timing_i (.sys_clk(sys_clk), .resetn(resetn),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .clock_source_select(ext_sel),
      .memory_clock_pin_i(mem_i), .memory_clock_pin_o(mem_o), .memory_clock_pin_oe(mem_oe),
      .video_clock_pin_i(vid_i), .video_clock_pin_o(vid_o), .video_clock_pin_oe(vid_oe),
      .synth_enable(synth_en), .link_clk(link_clk), .frame_start_marker(fsm),
      .line_pulse(lp), .panel_shift_clock(sc1), .second_shift_clock(sc2),
      .panel_h_display_enable(hde), .panel_logic_power_ctl(lpwr),
      .panel_bias_power_ctl(bpwr));
   clock_far_side clock_far_side_i (.link_clk(link_clk), .ext_mode(ext_sel),
      .mem_level(mem_lvl), .vid_level(vid_lvl), .mem_o(mem_o), .mem_oe(mem_oe),
      .vid_o(vid_o), .vid_oe(vid_oe), .mem_i(mem_i), .vid_i(vid_i));

   // ****************************************************************
   // clocks, watchdog and panel monitor
   // ****************************************************************
   initial begin sys_clk = 0; forever #4 sys_clk = !sys_clk; end
   initial begin link_clk = 0; #1.7; forever #3 link_clk = !link_clk; end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         $display("ERROR %0t watchdog expired", $time);
         print_verdict();
      end
   end
   always @(posedge link_clk)
   begin
      fs_q <= fsm;
      lp_q <= lp;
      sc1_q <= sc1;
      sc2_q <= sc2;
      hde_cyc <= hde_cyc + (hde === 1'b1);
      sc1_up <= sc1_up + (sc1 === 1'b1 && sc1_q === 1'b0);
      sc2_up <= sc2_up + (sc2 === 1'b1 && sc2_q === 1'b0);
      mo_q <= mem_o;
      vo_q <= vid_o;
      mo_up <= mo_up + (mem_o === 1'b1 && mo_q === 1'b0);
      vo_up <= vo_up + (vid_o === 1'b1 && vo_q === 1'b0);
      if (fsm === 1'b1 && fs_q === 1'b0)
      begin
         frames <= frames + 1;
         lines_last <= lines;
         lines <= (lp === 1'b1 && lp_q === 1'b0);
         hde_last <= hde_frame;
         hde_frame <= (hde === 1'b1);
         flips <= flips + (hde !== hde_fs);
         hde_fs <= hde;
      end
      else
      begin
         lines <= lines + (lp === 1'b1 && lp_q === 1'b0);
         hde_frame <= hde_frame + (hde === 1'b1);
      end
   end

   // ****************************************************************
   // bus cycles and comparisons
   // ****************************************************************
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      // hold the request until ack is seen high; only the watchdog ends a wait
      @(posedge sys_clk);
      while (ack !== 1'b1) @(posedge sys_clk);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t word got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_pin(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 4'hF, 32'h0);
      check_word(q, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wait_frames(input int n);
      int t;
      t = frames + n;
      while (frames < t) @(posedge sys_clk);
   endtask
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ****************************************************************
   // tests
   // ****************************************************************
   initial
   begin
      {resetn, cyc, stb, we, adr, sel, wdat} = '0;
      {ext_sel, mem_lvl, vid_lvl} = 3'h0;
      settle(10);
      resetn <= 1'b1;
      settle(10);
      // reset values, unmapped place, write with lane 0 off
      rd(OFS_PIN_FUNCTION, 32'h0000_0000);
      rd(OFS_OUTPUT_CONTROL, 32'h0000_0000);
      rd(OFS_PANEL_CONTROL, 32'h0000_0000);
      rd(OFS_H_TIMING, 32'h0010_0020);
      rd(OFS_V_TIMING, 32'h0008_0010);
      bus(1'b1, 8'h18, 4'hF, 32'h0000_00FF);
      rd(8'h18, READ_UNMAPPED);
      bus(1'b1, OFS_PIN_FUNCTION, 4'hE, 32'h0000_0083);
      rd(OFS_PIN_FUNCTION, 32'h0000_0000);
      rd(OFS_GENERAL_STATUS, 32'h0000_0000);
      check_pin(synth_en, 1'b1);
      $display("test registers done");
      // shared clock pins as status inputs
      bus(1'b1, OFS_PIN_FUNCTION, 4'hF, 32'h0000_0003);
      mem_lvl <= 1'b1;
      settle(12);
      rd(OFS_GENERAL_STATUS, 32'h0000_0002);
      check_pin(mem_oe, 1'b0);
      {mem_lvl, vid_lvl} <= 2'h1;
      settle(12);
      rd(OFS_GENERAL_STATUS, 32'h0000_0004);
      check_pin(vid_oe, 1'b0);
      bus(1'b1, OFS_PIN_FUNCTION, 4'hF, 32'h0000_0080);
      settle(12);
      check_pin(mem_oe, 1'b0);
      check_pin(vid_oe, 1'b1);
      $display("test pin functions done");
      // external clock mode
      bus(1'b1, OFS_PIN_FUNCTION, 4'hF, 32'h0000_0000);
      ext_sel <= 1'b1;
      settle(12);
      check_pin(synth_en, 1'b0);
      check_pin(mem_oe | vid_oe, 1'b0);
      rd(OFS_GENERAL_STATUS, 32'h0000_0001);
      ext_sel <= 1'b0;
      settle(12);
      check_pin(synth_en, 1'b1);
      check_pin(mem_oe & vid_oe, 1'b1);
      m0 = mo_up;
      s0 = vo_up;
      settle(12);
      check_pin(mo_up > m0, 1'b1);
      check_pin(vo_up > s0, 1'b1);
      $display("test clock source done");
      // panel timing, power and second shift clock
      bus(1'b1, OFS_PANEL_CONTROL, 4'hF, 32'h0000_0019);
      bus(1'b1, OFS_OUTPUT_CONTROL, 4'hF, 32'h0000_0003);
      settle(12);
      check_pin(lpwr, 1'b1);
      check_pin(bpwr, 1'b1);
      check_pin(sc2, 1'b1);
      wait_frames(3);
      check_word(lines_last, {20'h0, RST_V_TOTAL});
      check_word(hde_last, {20'h0, RST_H_ACTIVE} * {20'h0, RST_V_ACTIVE});
      check_pin(hde_cyc > 0, 1'b1);
      check_pin(sc1_up > 0, 1'b1);
      bus(1'b1, OFS_OUTPUT_CONTROL, 4'hF, 32'h0000_0001);
      settle(12);
      check_pin(sc2, 1'b0);
      s0 = sc2_up;
      bus(1'b1, OFS_PANEL_CONTROL, 4'hF, 32'h0000_0007);
      settle(12);
      check_pin(lpwr | bpwr, 1'b0);
      f0 = flips;
      wait_frames(1);
      f0 = flips;
      wait_frames(3);
      check_pin(flips > f0, 1'b1);
      check_pin(sc2_up > s0, 1'b1);
      $display("test panel done");
      print_verdict();
   end
endmodule
